// *** boot_loader_pkg.sv ***
// package: constants, states and timing for the boot and flash image loader
`default_nettype none
package boot_loader_pkg;
  localparam int unsigned CLK_HZ            = 25000000;
  localparam int unsigned SPI_HZ            = 12000000;
  // spi half period rounds up so the flash clock never exceeds 12 MHz
  localparam int unsigned SPI_HALF_CYC      = (CLK_HZ + 2 * SPI_HZ - 1) / (2 * SPI_HZ);
  localparam int unsigned LP_HZ             = 100000;
  localparam int unsigned LP_DIV_CYC        = CLK_HZ / (2 * LP_HZ);
  localparam logic [7:0]  TRIM_SETTLE_CYC   = 8'h40;
  localparam logic [7:0]  PERSIST_CYC       = 8'h80;
  localparam logic [23:0] LOW_HEADER_ADDR   = 24'h000000;
  localparam logic [23:0] HIGH_HEADER_ADDR  = 24'h001000;
  localparam logic [7:0]  FLASH_READ_CMD    = 8'h03;
  localparam int unsigned HDR_WORDS         = 2;
  localparam int unsigned CFG_WORDS         = 8;
  localparam logic [31:0] ERASED_WORD       = 32'hffffffff;
  localparam logic [1:0]  ADDR_TOP_BITS     = 2'b01;
  localparam logic [2:0]  ADDR_LOW_BITS     = 3'b111;

  typedef enum logic [3:0] {
    ST_OTP      = 4'h0,
    ST_TRIM     = 4'h1,
    ST_PERSIST  = 4'h2,
    ST_ENABLE   = 4'h3,
    ST_I2C      = 4'h4,
    ST_DEADBAT  = 4'h5,
    ST_HDR      = 4'h6,
    ST_IMAGE    = 4'h7,
    ST_DONE     = 4'h8,
    ST_INVALID  = 4'h9
  } boot_state_t;
endpackage : boot_loader_pkg
`default_nettype wire

// *** cfg_store.sv ***
// small configuration word memory with registered read data
`default_nettype none
module cfg_store (
  // clock
  input  wire logic        clk,
  // write port
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  // read port
  input  wire logic [2:0]  rd_addr,
  output logic      [31:0] rd_data
);
  logic [31:0] mem [8];

  // no reset on storage; contents are only valid after a load
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : cfg_store
`default_nettype wire

// *** boot_flash_image_loader.sv ***
// boot sequencer: supply settle, i2c address, dead battery, spi flash image load
`default_nettype none
// Behaviour
// - regulator power-on reset starts boot sequence
// - otp boot, trim load and settle
// - i2c address from two strap pins
// - open limited host interface after addressing
// - main clock on, persistence counters check supplies
// - enable thermal, converter, crc, gpio, interrupts
// - main invalid, vbus valid means dead battery
// - dead battery samples power path select
// - dead battery check follows i2c configuration
// - flash holds low and high regions
// - headers at 0x000000 and 0x001000
// - image address is pointer plus offset
// - first image words are configuration
// - header pointers validated, never assumed
// - provide 100 kHz low-power timer clock
// - low region first, then high, then invalid
// - invalid flash exposes debug on sideband
// - address is 01, straps, 111
module boot_flash_image_loader
  import boot_loader_pkg::*;
(
  // clock and reset (reset from regulator power-on detector)
  input  wire logic        clk,
  input  wire logic        reset_n,
  // supply and strap pins
  input  wire logic        internal_regulator_ok,
  input  wire logic        main_supply_input,
  input  wire logic        vbus_valid,
  input  wire logic [1:0]  address_strap_pins,
  input  wire logic        bus_power_path_select,
  // spi flash
  output logic             flash_select_n,
  output logic             flash_clk,
  output logic             flash_mosi,
  input  wire logic        flash_miso,
  // status and enables
  output logic             main_clk_en,
  output logic             trim_loaded,
  output logic             periph_en,
  output logic [6:0]      i2c_address,
  output logic             host_if_open,
  output logic             dead_battery,
  output logic             power_path_sel,
  output logic             power_path_valid,
  output logic             app_loaded,
  output logic             app_from_high,
  output logic             invalid_memory,
  output logic             swd_on_sideband,
  output logic             lp_clk,
  // configuration readback
  input  wire logic [2:0]  cfg_rd_addr,
  output logic      [31:0] cfg_rd_data
);
  // two-flop synchronisers for pins
  logic [5:0] pin_s1, pin_s2;
  always_ff @(posedge clk) begin
    pin_s1 <= {internal_regulator_ok, main_supply_input, vbus_valid,
               address_strap_pins, bus_power_path_select};
    pin_s2 <= pin_s1;
  end
  logic reg_ok_s, main_s, vbus_s, bps_s;
  logic [1:0] strap_s;
  assign {reg_ok_s, main_s, vbus_s, strap_s, bps_s} = pin_s2;

  function automatic logic [6:0] make_addr(input logic [1:0] s);
    make_addr = {ADDR_TOP_BITS, s[1], s[0], ADDR_LOW_BITS};
  endfunction : make_addr

  // 33-bit sum so a carry out of pointer plus offset still marks the region bad
  function automatic logic [32:0] image_sum(input logic [31:0] p, input logic [31:0] o);
    image_sum = {1'b0, p} + {1'b0, o};
  endfunction : image_sum

  // sequencer state
  boot_state_t state, next_state;
  logic [7:0]  cnt, next_cnt;
  logic        hi, next_hi;                // region under test
  logic [31:0] ptr, next_ptr;
  logic [3:0]  word, next_word;           // words received in current read
  logic        rd_go, next_rd_go;
  logic        rd_stop, next_rd_stop;     // cut the running read short
  logic [23:0] rd_addr, next_rd_addr;
  logic [3:0]  rd_len, next_rd_len;
  logic        i2c_done, next_i2c_done;
  logic        db, next_db, pps, next_pps, ppv, next_ppv;
  // spi engine
  logic        busy, next_busy;
  logic        fin, next_fin;             // last bit taken, close on falling edge
  logic [5:0]  bitn, next_bitn;
  logic [1:0]  div, next_div;
  logic        sclk, next_sclk, csn, next_csn, mosi, next_mosi;
  logic [31:0] sh, next_sh;
  logic [3:0]  left, next_left;
  logic        wvalid, next_wvalid;
  logic [31:0] wdata, next_wdata;
  logic [8:0]  lpc, next_lpc;
  logic        lpk, next_lpk;
  logic        cfg_we;

  // spi mode 0 word reader: cmd+addr then 32-bit words, msb first
  always_comb begin
    next_busy = busy; next_bitn = bitn; next_div = div; next_sclk = sclk;
    next_csn = csn; next_mosi = mosi; next_sh = sh; next_left = left;
    next_wvalid = 1'b0; next_wdata = wdata;
    next_fin = fin;
    if (!busy && rd_go) begin
      next_busy = 1'b1; next_csn = 1'b0; next_bitn = 6'h00; next_div = 2'h0;
      next_sh = {FLASH_READ_CMD, rd_addr}; next_left = rd_len;
      next_mosi = FLASH_READ_CMD[7];        // data valid as select goes low
    end else if (busy) begin
      next_div = div + 2'h1;
      if (div == 2'(SPI_HALF_CYC - 1)) begin
        next_div = 2'h0;
        next_sclk = ~sclk;
        if (!sclk && (fin || rd_stop)) begin
          // a stop seen with the clock low ends without another rising edge
          next_sclk = 1'b0;
          next_busy = 1'b0; next_csn = 1'b1; next_fin = 1'b0;
        end else if (!sclk) begin           // rising edge: sample
          next_sh = {sh[30:0], flash_miso};
          next_bitn = bitn + 6'h01;
          if (bitn == 6'h1f) begin
            next_bitn = 6'h00;
            if (!csn && left != rd_len) begin
              next_wvalid = 1'b1;
              next_wdata = {sh[30:0], flash_miso};
            end
            if (left == 4'h0) begin
              next_fin = 1'b1;              // deselect waits for the clock to fall
            end else begin
              next_left = left - 4'h1;
            end
          end
        end else if (fin || rd_stop) begin
          // select rises only with the clock low, so the idle level holds
          next_busy = 1'b0; next_csn = 1'b1; next_fin = 1'b0;
        end else begin
          next_mosi = sh[31];               // falling edge: shift out
        end
      end
    end
    if (!busy && !rd_go) begin
      next_sclk = 1'b0;
      next_csn = 1'b1;
    end
  end

  // boot sequencer
  always_comb begin
    next_state = state; next_cnt = cnt; next_hi = hi; next_ptr = ptr;
    // a start request waits while the engine is still closing a read
    next_word = word; next_rd_go = rd_go && busy; next_rd_addr = rd_addr;
    next_rd_stop = rd_stop && busy;
    next_rd_len = rd_len; next_i2c_done = i2c_done;
    next_db = db; next_pps = pps; next_ppv = ppv;
    cfg_we = 1'b0;
    unique case (state)
      ST_OTP: if (reg_ok_s) next_state = ST_TRIM;
      ST_TRIM: begin
        next_cnt = cnt + 8'h01;
        if (cnt == TRIM_SETTLE_CYC) begin
          next_cnt = 8'h00; next_state = ST_PERSIST;
        end
      end
      ST_PERSIST: begin
        // supply must stay good for the whole persistence window
        if (main_s || vbus_s) next_cnt = cnt + 8'h01;
        else next_cnt = 8'h00;
        if (cnt == PERSIST_CYC) next_state = ST_ENABLE;
      end
      ST_ENABLE: next_state = ST_I2C;
      ST_I2C: begin
        next_i2c_done = 1'b1;
        next_state = ST_DEADBAT;
      end
      ST_DEADBAT: begin
        if (!main_s && vbus_s) begin
          next_db = 1'b1; next_pps = bps_s; next_ppv = 1'b1;
        end
        next_hi = 1'b0; next_word = 4'h0; next_rd_go = 1'b1;
        next_rd_addr = LOW_HEADER_ADDR; next_rd_len = 4'(HDR_WORDS);
        next_state = ST_HDR;
      end
      ST_HDR: if (wvalid) begin
        next_word = word + 4'h1;
        if (word == 4'h0) next_ptr = wdata;
        else begin
          next_ptr = ptr + wdata;
          // erased or out-of-range pointer marks the region bad
          if (ptr == ERASED_WORD || wdata == ERASED_WORD ||
              image_sum(ptr, wdata) > 33'h000ffffff) begin
            next_rd_go = ~hi;
            next_hi = 1'b1;
            next_word = 4'h0;
            next_rd_addr = HIGH_HEADER_ADDR;
            next_state = hi ? ST_INVALID : ST_HDR;
          end else begin
            next_word = 4'h0; next_rd_go = 1'b1;
            next_rd_addr = 24'(image_sum(ptr, wdata));
            next_rd_len = 4'(CFG_WORDS);
            next_state = ST_IMAGE;
          end
        end
      end
      ST_IMAGE: if (wvalid) begin
        cfg_we = 1'b1;
        next_word = word + 4'h1;
        if (word == 4'h0 && wdata == ERASED_WORD) begin
          cfg_we = 1'b0; next_word = 4'h0;
          next_rd_go = ~hi; next_hi = 1'b1; next_rd_addr = HIGH_HEADER_ADDR;
          next_rd_stop = 1'b1;                 // abandon the rest of the image
          next_rd_len = 4'(HDR_WORDS);
          next_state = hi ? ST_INVALID : ST_HDR;
        end else if (word == 4'(CFG_WORDS - 1)) next_state = ST_DONE;
      end
      ST_DONE:    next_state = ST_DONE;
      ST_INVALID: next_state = ST_INVALID;
      default:    next_state = ST_OTP;
    endcase
  end

  // 100 kHz low-power clock divider
  always_comb begin
    next_lpc = lpc + 9'h001;
    next_lpk = lpk;
    if (lpc == 9'(LP_DIV_CYC - 1)) begin
      next_lpc = 9'h000; next_lpk = ~lpk;
    end
  end

  // registers; the hidden word count in rd engine starts one ahead
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_OTP; cnt <= 8'h00; hi <= 1'b0; ptr <= 32'h00000000;
      word <= 4'h0; rd_go <= 1'b0; rd_addr <= 24'h000000; rd_len <= 4'h0;
      i2c_done <= 1'b0; db <= 1'b0; pps <= 1'b0; ppv <= 1'b0;
      busy <= 1'b0; bitn <= 6'h00; div <= 2'h0; sclk <= 1'b0; csn <= 1'b1;
      mosi <= 1'b0; sh <= 32'h00000000; left <= 4'h0; wvalid <= 1'b0;
      wdata <= 32'h00000000; lpc <= 9'h000; lpk <= 1'b0;
      fin <= 1'b0; rd_stop <= 1'b0;
      main_clk_en <= 1'b0; trim_loaded <= 1'b0; periph_en <= 1'b0;
      i2c_address <= 7'h00; host_if_open <= 1'b0; app_loaded <= 1'b0;
      app_from_high <= 1'b0; invalid_memory <= 1'b0; swd_on_sideband <= 1'b0;
    end else begin
      state <= next_state; cnt <= next_cnt; hi <= next_hi; ptr <= next_ptr;
      word <= next_word; rd_go <= next_rd_go; rd_addr <= next_rd_addr;
      rd_len <= next_rd_len; i2c_done <= next_i2c_done;
      db <= next_db; pps <= next_pps; ppv <= next_ppv;
      busy <= next_busy; bitn <= next_bitn; div <= next_div; sclk <= next_sclk;
      csn <= next_csn; mosi <= next_mosi; sh <= next_sh; left <= next_left;
      wvalid <= next_wvalid; wdata <= next_wdata; lpc <= next_lpc; lpk <= next_lpk;
      fin <= next_fin; rd_stop <= next_rd_stop;
      main_clk_en <= (state != ST_OTP && state != ST_TRIM);
      trim_loaded <= (state != ST_OTP && state != ST_TRIM);
      periph_en <= (state >= ST_ENABLE && state != ST_OTP);
      if (state == ST_I2C) i2c_address <= make_addr(strap_s);
      host_if_open <= next_i2c_done;
      app_loaded <= (next_state == ST_DONE);
      app_from_high <= next_hi && next_state == ST_DONE;
      invalid_memory <= (next_state == ST_INVALID);
      swd_on_sideband <= (next_state == ST_INVALID);
    end
  end

  // direct flop outputs
  assign flash_select_n   = csn;
  assign flash_clk        = sclk;
  assign flash_mosi       = mosi;
  assign dead_battery     = db;
  assign power_path_sel   = pps;
  assign power_path_valid = ppv;
  assign lp_clk           = lpk;

  cfg_store u_cfg (
    .clk     (clk),
    .wr_en   (cfg_we),
    .wr_addr (word[2:0]),
    .wr_data (wdata),
    .rd_addr (cfg_rd_addr),
    .rd_data (cfg_rd_data)
  );
endmodule : boot_flash_image_loader
`default_nettype wire

// *** boot_flash_image_loader_checker.sv ***
// checker: ordering and pin relations of the boot sequencer
`default_nettype none
module boot_flash_image_loader_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // watched outputs
  input wire logic       flash_select_n,
  input wire logic       flash_clk,
  input wire logic       main_clk_en,
  input wire logic       trim_loaded,
  input wire logic       periph_en,
  input wire logic [6:0] i2c_address,
  input wire logic       host_if_open,
  input wire logic       dead_battery,
  input wire logic       power_path_valid,
  input wire logic       app_loaded,
  input wire logic       invalid_memory,
  input wire logic       swd_on_sideband,
  input wire logic       lp_clk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // reset must clear the sequence whatever state it was in
  property p_reset; disable iff (1'b0)
    !reset_n |=> flash_select_n && !app_loaded && !host_if_open && !main_clk_en; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_addr; host_if_open |-> i2c_address[6:5] == 2'b01 && i2c_address[2:0] == 3'b111;
  endproperty
  a_addr: assert property (p_addr) else $error("fixed address bits wrong");
  property p_host; $rose(host_if_open) |-> periph_en && trim_loaded && main_clk_en; endproperty
  a_host: assert property (p_host) else $error("host opened before init done");
  // no flash traffic before supplies and address are settled
  property p_flash; !flash_select_n |-> host_if_open && periph_en; endproperty
  a_flash: assert property (p_flash) else $error("flash access too early");
  property p_dbo; dead_battery |-> host_if_open; endproperty
  a_dbo: assert property (p_dbo) else $error("dead battery before address set");
  property p_path; $rose(dead_battery) |-> ##[0:3] power_path_valid; endproperty
  a_path: assert property (p_path) else $error("power path not configured");
  property p_idle; flash_select_n |-> !flash_clk; endproperty
  a_idle: assert property (p_idle) else $error("flash clock not idle low");
  property p_swd; $rose(invalid_memory) |-> ##[0:2] swd_on_sideband; endproperty
  a_swd: assert property (p_swd) else $error("debug not exposed");
  property p_one; !(app_loaded && invalid_memory); endproperty
  a_one: assert property (p_one) else $error("loaded and invalid together");
  // slow clock half period is far above eight cycles
  property p_lp; $changed(lp_clk) |=> $stable(lp_clk) [*8]; endproperty
  a_lp: assert property (p_lp) else $error("low power clock too fast");
endmodule : boot_flash_image_loader_checker
bind boot_flash_image_loader boot_flash_image_loader_checker chk (.clk, .reset_n,
  .flash_select_n, .flash_clk, .main_clk_en, .trim_loaded, .periph_en, .i2c_address,
  .host_if_open, .dead_battery, .power_path_valid, .app_loaded, .invalid_memory,
  .swd_on_sideband, .lp_clk);
`default_nettype wire

// *** spi_flash_model.sv ***
// spi nor flash model: read command, byte storage
`default_nettype none
module spi_flash_model (
  // spi pins
  input  wire logic flash_select_n,
  input  wire logic flash_clk,
  input  wire logic flash_mosi,
  output logic      flash_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:16383];
  logic [31:0] hdr;
  int          nbit = 0;
  initial flash_miso = 1'b0;
  // command and address taken on rising edge
  always @(posedge flash_clk) begin
    if (nbit < 32) hdr = {hdr[30:0], flash_mosi};
    nbit = nbit + 1;
  end
  // data shifted out on falling edge, msb first
  always @(negedge flash_clk) begin
    if (nbit >= 32 && hdr[31:24] == 8'h03)
      flash_miso = mem[14'(hdr[23:0] + (nbit - 32) / 8)][7 - (nbit - 32) % 8];
  end
  // no pull-up on this line: a released line shows the inverse of the last bit
  always @(posedge flash_select_n) flash_miso = ~flash_miso;
  always @(negedge flash_select_n) nbit = 0;
endmodule : spi_flash_model
`default_nettype wire

// *** boot_flash_image_loader_test.sv ***
// testbench: boot order, strap address, dead battery, flash region fallback
`default_nettype none
module boot_flash_image_loader_test;
  import boot_loader_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, internal_regulator_ok, main_supply_input, vbus_valid;
  logic bus_power_path_select, flash_select_n, flash_clk, flash_mosi, flash_miso;
  logic main_clk_en, trim_loaded, periph_en, host_if_open, dead_battery, lp_clk;
  logic power_path_sel, power_path_valid, app_loaded, app_from_high;
  logic invalid_memory, swd_on_sideband;
  logic [1:0]  address_strap_pins;
  logic [6:0]  i2c_address;
  logic [2:0]  cfg_rd_addr;
  logic [31:0] cfg_rd_data;
  int err_total = 0, checks_done = 0, cyc = 0;
  longint t0;
  boot_flash_image_loader dut (.clk, .reset_n, .internal_regulator_ok, .main_supply_input,
    .vbus_valid, .address_strap_pins, .bus_power_path_select, .flash_select_n, .flash_clk,
    .flash_mosi, .flash_miso, .main_clk_en, .trim_loaded, .periph_en, .i2c_address,
    .host_if_open, .dead_battery, .power_path_sel, .power_path_valid, .app_loaded,
    .app_from_high, .invalid_memory, .swd_on_sideband, .lp_clk, .cfg_rd_addr, .cfg_rd_data);
  spi_flash_model flash (.flash_select_n, .flash_clk, .flash_mosi, .flash_miso);
  initial clk = 1'b0;
  always #20 clk = ~clk;
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // four boots need well under fifteen thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic put(int a, logic [31:0] w);
    for (int b = 0; b < 4; b++) flash.mem[a + b] = w[31 - 8 * b -: 8];
  endtask : put
  // image: header pair, then eight configuration words
  task automatic image(int hdr, int ptr, int off, logic [31:0] base);
    put(hdr, ptr);
    put(hdr + 4, off);
    for (int i = 0; i < 8; i++) put(ptr + off + 4 * i, base + i);
  endtask : image
  task automatic cfg_check(logic [31:0] base);
    for (int i = 0; i < 8; i++) begin
      cfg_rd_addr = 3'(i);
      @(negedge clk);
      check("cfg word", cfg_rd_data, base + i);
    end
  endtask : cfg_check
  // reset, hold regulator low, then run; a main supply dropout restarts persistence unless vbus is valid
  task automatic boot(logic m, logic v, logic p, logic [1:0] s);
    int n;
    reset_n = 1'b0;
    internal_regulator_ok = 1'b0;
    main_supply_input = m;
    vbus_valid = v;
    bus_power_path_select = p;
    address_strap_pins = s;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (20) @(negedge clk);
    check("clk en early", 32'(main_clk_en), 0);
    internal_regulator_ok = 1'b1;
    repeat (40) @(negedge clk);
    check("trim early", 32'(trim_loaded), 0);
    repeat (60) @(negedge clk);
    check("trim", 32'(trim_loaded), 1);
    check("host early", 32'(host_if_open), 0);
    main_supply_input = 1'b0;
    @(negedge clk);
    main_supply_input = m;
    repeat (114) @(negedge clk);
    if (m) check("persist restart", 32'(host_if_open), 0);
    n = 0;
    while (app_loaded !== 1'b1 && invalid_memory !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    check("boot ends", 32'(n < 6000), 1);
    check("host open", 32'(host_if_open), 1);
    check("periph", 32'(periph_en), 1);
    check("dead bat", 32'(dead_battery), 32'(!m && v));
  endtask : boot
  // the first boot call drives reset and the pins at time zero
  initial begin
    cfg_rd_addr = 3'h0;
    for (int a = 0; a < 16384; a++) flash.mem[a] = 8'hff;
    // low region good, main supply valid
    image(32'h0, 32'h800, 32'h10, 32'h5a0c3e00);
    boot(1'b1, 1'b0, 1'b0, 2'b10);
    check("i2c addr", 32'(i2c_address), 32'h37);
    check("low used", {app_loaded, app_from_high}, 32'h2);
    cfg_check(32'h5a0c3e00);
    // updater left the low header erased and put a new image in the high one
    for (int a = 0; a < 8; a++) flash.mem[a] = 8'hff;
    image(32'h1000, 32'h2000, 32'h40, 32'ha5f0c100);
    boot(1'b0, 1'b1, 1'b1, 2'b01);
    check("i2c addr", 32'(i2c_address), 32'h2f);
    check("path sel", {power_path_sel, power_path_valid}, 32'h3);
    check("high used", {app_loaded, app_from_high}, 32'h3);
    cfg_check(32'ha5f0c100);
    // low header valid again but its image erased: the image read is cut short
    put(32'h0, 32'h800);
    put(32'h4, 32'h10);
    put(32'h810, ERASED_WORD);
    boot(1'b1, 1'b0, 1'b0, 2'b00);
    check("i2c addr", 32'(i2c_address), 32'h27);
    check("path sel", {power_path_sel, power_path_valid}, 32'h0);
    check("high used", {app_loaded, app_from_high}, 32'h3);
    cfg_check(32'ha5f0c100);
    check("select idle", 32'(flash_select_n), 1);
    // high header erased too: low fails in its image, high in its header
    for (int a = 32'h1000; a < 32'h1008; a++) flash.mem[a] = 8'hff;
    boot(1'b0, 1'b1, 1'b0, 2'b11);
    check("i2c addr", 32'(i2c_address), 32'h3f);
    check("path sel", {power_path_sel, power_path_valid}, 32'h1);
    check("invalid", {invalid_memory, swd_on_sideband, app_loaded}, 32'h6);
    @(posedge lp_clk);
    t0 = $time;
    @(posedge lp_clk);
    check("lp period", 32'(($time - t0) / 40), 2 * LP_DIV_CYC);
    check("select idle", 32'(flash_select_n), 1);
    report_and_stop();
  end
endmodule : boot_flash_image_loader_test
`default_nettype wire
